// file: common/acf_pkg.sv
// Package of channel configuration constants and register map for the channel FIFO block
package acf_pkg;
  localparam int NUM_CH        = 6;
  localparam int DATA_W        = 8;
  localparam int DEPTH         = 16;
  localparam int PTR_W         = 4;
  localparam int CNT_W         = 5;
  // Channel indices
  localparam int CH_WADDR      = 0;
  localparam int CH_WDATA      = 1;
  localparam int CH_WRESP      = 2;
  localparam int CH_RADDR      = 3;
  localparam int CH_RDATA      = 4;
  localparam int CH_STREAM     = 5;
  // Option codes
  localparam logic OPT_OFF     = 1'b0;
  localparam logic OPT_ON      = 1'b1;
  localparam logic [2:0] SRC_THRESH_A = 3'h1;
  localparam logic [2:0] SRC_THRESH_B = 3'h3;
  localparam logic [2:0] SRC_HARD     = 3'h5;
  localparam logic [2:0] SRC_ONE_LEFT = 3'h6;
  localparam logic [1:0] USE_DATA     = 2'h0;
  localparam logic [1:0] USE_PACKET   = 2'h1;
  localparam logic [1:0] USE_LOWLAT   = 2'h2;
  // Build-time per-channel configuration, one entry per channel
  localparam logic [NUM_CH-1:0] COUNT_OPTION  = 6'b11_1111;
  localparam logic [NUM_CH-1:0] FLAG_OPTION   = 6'b11_1111;
  localparam logic [NUM_CH-1:0] COMMON_CLOCK  = 6'b11_1111;
  localparam logic [2:0] READY_SRC [NUM_CH] = '{3'h5, 3'h1, 3'h6, 3'h3, 3'h5, 3'h1};
  localparam logic [2:0] VALID_SRC [NUM_CH] = '{3'h5, 3'h1, 3'h6, 3'h3, 3'h5, 3'h1};
  localparam logic [1:0] USAGE     [NUM_CH] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1};
  localparam logic [CNT_W-1:0] HIGH_THRESH [NUM_CH] =
    '{5'h0c, 5'h0e, 5'h0a, 5'h0c, 5'h0e, 5'h0d};
  localparam logic [CNT_W-1:0] LOW_THRESH  [NUM_CH] =
    '{5'h02, 5'h03, 5'h01, 5'h02, 5'h04, 5'h02};
  // Register map, byte addresses
  localparam logic [3:0] ADDR_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
  localparam logic [3:0] ADDR_COUNT_LO = 4'hc;
  localparam int IRQ_W = 2 * NUM_CH;
endpackage : acf_pkg

// file: core/acf_channel_fifo.sv
// Six independent channel FIFOs with flag-mapped handshakes and an Avalon-MM status port
`timescale 1ns/1ns
// Overview of operation
// - A channel with its count option off drives zero on count_o yet still shows its count at ADDR_COUNT_LO, otherwise one count in shared-clock form.
// - The flag option off keeps plain full/empty handshakes, on lets a chosen flag drive ready and valid.
// - Ready follows the threshold-high flag for select 1 or 3, full for 5 and one-slot-left for 6.
// - Valid follows the threshold-low flag for select 1 or 3, empty for 5 and one-entry-left for 6.
// - Each channel has its own build-time high and low assert thresholds.
// - Packet mode exists only on shared-clock channels and is refused on independent-clock ones.
// - Usage select 0 is a data FIFO, 1 a packet FIFO and 2 a low-latency data FIFO.
module acf_channel_fifo (
  input  wire logic                                 mclk_i,
  input  wire logic                                 sys_rst_i,
  input  wire logic [acf_pkg::NUM_CH-1:0]               s_valid_i,
  input  wire logic [acf_pkg::NUM_CH*acf_pkg::DATA_W-1:0] s_data_i,
  input  wire logic [acf_pkg::NUM_CH-1:0]               s_last_i,
  output logic      [acf_pkg::NUM_CH-1:0]               s_ready_o,
  output logic      [acf_pkg::NUM_CH-1:0]               m_valid_o,
  output logic      [acf_pkg::NUM_CH*acf_pkg::DATA_W-1:0] m_data_o,
  input  wire logic [acf_pkg::NUM_CH-1:0]               m_ready_i,
  output logic      [acf_pkg::NUM_CH*acf_pkg::CNT_W-1:0]  count_o,
  input  wire logic [3:0]                             avs_address_i,
  input  wire logic                                 avs_read_i,
  input  wire logic                                 avs_write_i,
  input  wire logic [31:0]                            avs_writedata_i,
  output logic      [31:0]                            avs_readdata_o,
  output logic                                      avs_waitrequest_o,
  output logic                                      irq_o
);
  localparam int N  = acf_pkg::NUM_CH;
  localparam int DW = acf_pkg::DATA_W;
  localparam int CW = acf_pkg::CNT_W;

  logic [N-1:0]    full_w;
  logic [N-1:0]    empty_w;
  logic [N-1:0]    hi_w;
  logic [N-1:0]    lo_w;
  logic [N-1:0]    wr_en_w;
  logic [N-1:0]    rd_en_w;
  logic [CW-1:0]   cnt_w [N];
  localparam int IRQW = acf_pkg::IRQ_W;
  logic [IRQW-1:0] irq_stat_reg;
  logic [IRQW-1:0] irq_mask_reg;
  logic [IRQW-1:0] irq_set_w;
  logic [N-1:0]    over_w;
  logic [N-1:0]    under_w;
  logic            ack_reg;
  logic            wr_stb_w;
  logic            rd_stb_w;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_ch
      logic [DW-1:0]          mem_reg [acf_pkg::DEPTH];
      logic [acf_pkg::PTR_W-1:0] wptr_reg;
      logic [acf_pkg::PTR_W-1:0] rptr_reg;
      logic [CW-1:0]          cnt_reg;
      logic [CW-1:0]          pkts_reg;
      logic                   pkt_mode;
      logic                   rd_last;
      logic                   wr_ok;
      logic                   rd_ok;
      // Storage itself is not reset; pointers and counts define what is held
      logic                   last_mem_reg [acf_pkg::DEPTH];

      // Packet mode only where the channel shares one clock
      always_comb
      begin
        case (acf_pkg::USAGE[g])
          acf_pkg::USE_DATA,
          acf_pkg::USE_LOWLAT: pkt_mode = 1'b0;
          acf_pkg::USE_PACKET: pkt_mode = acf_pkg::COMMON_CLOCK[g];
          default:             pkt_mode = 1'b0;
        endcase
      end

      assign full_w[g]  = (cnt_reg == CW'(acf_pkg::DEPTH));
      assign empty_w[g] = (cnt_reg == '0);
      assign hi_w[g]    = (cnt_reg >= acf_pkg::HIGH_THRESH[g]);
      assign lo_w[g]    = (cnt_reg <= acf_pkg::LOW_THRESH[g]);

      // Selected full-type flag stalls the writer
      always_comb
      begin
        wr_ok = !full_w[g];
        if (acf_pkg::FLAG_OPTION[g] == acf_pkg::OPT_ON)
        begin
          case (acf_pkg::READY_SRC[g])
            acf_pkg::SRC_THRESH_A,
            acf_pkg::SRC_THRESH_B: wr_ok = !hi_w[g];
            acf_pkg::SRC_HARD:     wr_ok = !full_w[g];
            acf_pkg::SRC_ONE_LEFT: wr_ok = (cnt_reg < CW'(acf_pkg::DEPTH - 1));
            default:               wr_ok = !full_w[g];
          endcase
        end
      end

      // Threshold flags can hold back data already stored; low-latency usage reads the same as a plain data FIFO
      always_comb
      begin
        rd_ok = !empty_w[g];
        if (acf_pkg::FLAG_OPTION[g] == acf_pkg::OPT_ON)
        begin
          case (acf_pkg::VALID_SRC[g])
            acf_pkg::SRC_THRESH_A,
            acf_pkg::SRC_THRESH_B: rd_ok = !lo_w[g];
            acf_pkg::SRC_HARD:     rd_ok = !empty_w[g];
            acf_pkg::SRC_ONE_LEFT: rd_ok = (cnt_reg > CW'(1));
            default:               rd_ok = !empty_w[g];
          endcase
        end
        if (pkt_mode && pkts_reg == '0 && !full_w[g])
          rd_ok = 1'b0;
      end

      assign s_ready_o[g] = wr_ok;
      assign m_valid_o[g] = rd_ok && !empty_w[g];
      assign wr_en_w[g]   = s_valid_i[g] && wr_ok;
      assign rd_en_w[g]   = m_ready_i[g] && m_valid_o[g];
      assign rd_last      = last_mem_reg[rptr_reg];
      assign cnt_w[g]     = cnt_reg;
      assign m_data_o[g*DW +: DW] = mem_reg[rptr_reg];
      assign count_o[g*CW +: CW]  = acf_pkg::COUNT_OPTION[g] ? cnt_reg : '0;

      always_ff @(posedge mclk_i)
      begin
        if (wr_en_w[g])
        begin
          mem_reg[wptr_reg]      <= s_data_i[g*DW +: DW];
          last_mem_reg[wptr_reg] <= s_last_i[g];
        end
      end

      always_ff @(posedge mclk_i)
      begin
        if (sys_rst_i)
        begin
          wptr_reg <= '0;
          rptr_reg <= '0;
          cnt_reg  <= '0;
        end
        else
        begin
          if (wr_en_w[g])
            wptr_reg <= wptr_reg + 1'b1;
          if (rd_en_w[g])
            rptr_reg <= rptr_reg + 1'b1;
          cnt_reg <= cnt_reg + CW'(wr_en_w[g]) - CW'(rd_en_w[g]);
        end
      end

      // Whole packets stored; reads wait for a complete packet unless the channel is full
      always_ff @(posedge mclk_i)
      begin
        if (sys_rst_i)
          pkts_reg <= '0;
        else
          pkts_reg <= pkts_reg + CW'(wr_en_w[g] && s_last_i[g])
                      - CW'(rd_en_w[g] && rd_last);
      end
    end
  endgenerate

  // Events: overflow attempt (ready low) and underflow attempt (empty) per channel
  assign over_w    = s_valid_i & ~s_ready_o;
  assign under_w   = m_ready_i & empty_w;
  assign irq_set_w = {under_w, over_w};

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      irq_stat_reg <= '0;
    else if (wr_stb_w && avs_address_i == acf_pkg::ADDR_IRQ_STAT)
      // Set wins over a clear in the same cycle
      irq_stat_reg <= (irq_stat_reg & ~avs_writedata_i[IRQW-1:0]) | irq_set_w;
    else
      irq_stat_reg <= irq_stat_reg | irq_set_w;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      irq_mask_reg <= '0;
    else if (wr_stb_w && avs_address_i == acf_pkg::ADDR_IRQ_MASK)
      irq_mask_reg <= avs_writedata_i[IRQW-1:0];
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // One wait cycle per access keeps read data registered
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;

  // Writes land on the edge that ends the access, reads are sampled one edge earlier
  assign wr_stb_w = avs_write_i && ack_reg;
  assign rd_stb_w = avs_read_i && !ack_reg;

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      avs_readdata_o <= '0;
    else if (rd_stb_w)
    begin
      // Unmapped offsets read as zero
      case (avs_address_i)
        acf_pkg::ADDR_STATUS:   avs_readdata_o <= {8'h00, lo_w, hi_w, empty_w, full_w};
        acf_pkg::ADDR_IRQ_STAT: avs_readdata_o <= {20'h0_0000, irq_stat_reg};
        acf_pkg::ADDR_IRQ_MASK: avs_readdata_o <= {20'h0_0000, irq_mask_reg};
        acf_pkg::ADDR_COUNT_LO: avs_readdata_o <= {2'b00, cnt_w[5], cnt_w[4], cnt_w[3],
                                                   cnt_w[2], cnt_w[1], cnt_w[0]};
        default:                avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule : acf_channel_fifo

// file: tb/acf_monitor.sv
// Checker of the flag-to-handshake mapping at the block ports
`timescale 1ns/1ns
module acf_monitor (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [5:0]  s_valid_i,
  input  wire logic [5:0]  s_ready_o,
  input  wire logic [5:0]  m_valid_o,
  input  wire logic [5:0]  m_ready_i,
  input  wire logic [29:0] count_o,
  input  wire logic        avs_read_i,
  input  wire logic        avs_waitrequest_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  full_rdy_a: assert property (s_ready_o[0] == (count_o[4:0] < 5'h10))
    else $error("ready of channel 0 wrong");
  high_rdy_a: assert property (s_ready_o[1] == (count_o[9:5] < 5'h0e))
    else $error("ready of channel 1 wrong");
  alt_high_a: assert property (s_ready_o[3] == (count_o[19:15] < 5'h0c))
    else $error("ready of channel 3 wrong");
  left_rdy_a: assert property (s_ready_o[2] == (count_o[14:10] < 5'h0f))
    else $error("ready of channel 2 wrong");
  empty_vld_a: assert property (m_valid_o[0] == (count_o[4:0] != 5'h00))
    else $error("valid of channel 0 wrong");
  low_vld_a: assert property (m_valid_o[3] == (count_o[19:15] > 5'h02))
    else $error("valid of channel 3 wrong");
  left_vld_a: assert property (m_valid_o[2] == (count_o[14:10] > 5'h01))
    else $error("valid of channel 2 wrong");
  low_wdata_a: assert property (m_valid_o[1] == (count_o[9:5] > 5'h03))
    else $error("valid of channel 1 wrong");
  full_rdata_a: assert property (s_ready_o[4] == (count_o[24:20] < 5'h10))
    else $error("ready of channel 4 wrong");
  count_up_a: assert property (s_valid_i[4] && s_ready_o[4] && !m_ready_i[4]
    |=> count_o[24:20] == $past(count_o[24:20]) + 5'h01) else $error("count 4 stuck");
  bus_wait_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read wait state wrong");
endmodule : acf_monitor
bind acf_channel_fifo acf_monitor acf_monitor_i (.mclk_i, .sys_rst_i, .s_valid_i, .s_ready_o,
  .m_valid_o, .m_ready_i, .count_o, .avs_read_i, .avs_waitrequest_o);

// file: tb/acf_partner.sv
// Stream source and sink standing at the far side of all six channels
`timescale 1ns/1ns
module acf_partner (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [5:0]  push_i,
  input  wire logic [5:0]  pop_i,
  input  wire logic [5:0]  s_ready_i,
  output logic      [5:0]  s_valid_o,
  output logic      [47:0] s_data_o,
  output logic      [5:0]  s_last_o,
  output logic      [5:0]  m_ready_o
);
  logic [7:0] seq_reg [6];
  always_ff @(posedge mclk_i)
  begin
    for (int c = 0; c < 6; c++)
    begin
      if (sys_rst_i)
        seq_reg[c] <= 8'h00;
      else if (push_i[c] && s_ready_i[c])
        seq_reg[c] <= seq_reg[c] + 8'h01;
    end
  end
  always_comb
  begin
    for (int c = 0; c < 6; c++)
    begin
      // Idle byte inverted so a stale value is never taken for data
      s_data_o[c*8+:8] = push_i[c] ? seq_reg[c] : ~seq_reg[c];
      s_last_o[c] = push_i[c] && (seq_reg[c][1:0] == 2'h3);
    end
  end
  assign s_valid_o = push_i;
  assign m_ready_o = pop_i;
endmodule : acf_partner

// file: tb/tb_top.sv
// Self-checking bench for the six-channel flag-mapped FIFO
`timescale 1ns/1ns
module tb_top;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [5:0]  push = 6'h00, pop = 6'h00, s_valid, s_last, s_ready, m_valid, m_ready;
  logic [47:0] s_data, m_data;
  logic [29:0] count, e;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0, wr = 1'b0, wait_o, irq;
  logic [31:0] wdat = 32'h0000_0000, rdat, v;
  int          n_errors = 0, check_count = 0;
  int          idx [6];
  always #25 mclk_i = ~mclk_i;
  acf_partner acf_partner_i (.mclk_i, .sys_rst_i, .push_i(push), .pop_i(pop), .s_ready_i(s_ready),
    .s_valid_o(s_valid), .s_data_o(s_data), .s_last_o(s_last), .m_ready_o(m_ready));
  acf_channel_fifo acf_channel_fifo_i (.mclk_i, .sys_rst_i, .s_valid_i(s_valid), .s_data_i(s_data),
    .s_last_i(s_last), .s_ready_o(s_ready), .m_valid_o(m_valid), .m_data_o(m_data),
    .m_ready_i(m_ready), .count_o(count), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o), .irq_o(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    n = 0;
    do
    begin
      @(negedge mclk_i);
      n++;
    end
    while (wait_o !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      close_out();
    end
    @(posedge mclk_i);
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  // Level at which ready drops, and level at which valid drops
  function automatic logic [4:0] top(input int c);
    case (acf_pkg::READY_SRC[c])
      acf_pkg::SRC_HARD: return 5'h10;
      acf_pkg::SRC_ONE_LEFT: return 5'h0f;
      default: return acf_pkg::HIGH_THRESH[c];
    endcase
  endfunction : top
  function automatic logic [4:0] bot(input int c);
    case (acf_pkg::VALID_SRC[c])
      acf_pkg::SRC_HARD: return 5'h00;
      acf_pkg::SRC_ONE_LEFT: return 5'h01;
      default: return acf_pkg::LOW_THRESH[c];
    endcase
  endfunction : bot
  initial
  begin
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    chk(s_ready, 6'h3f);
    chk(m_valid, 6'h00);
    chk(count, 30'h0000_0000);
    $display("reset test done");
    @(posedge mclk_i);
    push <= 6'h3f;
    repeat (20) @(posedge mclk_i);
    push <= 6'h00;
    @(negedge mclk_i);
    for (int c = 0; c < 6; c++)
    begin
      e[c*5+:5] = top(c);
      chk(count[c*5+:5], top(c));
      chk(s_ready[c], 1'b0);
    end
    bus(1'b0, acf_pkg::ADDR_COUNT_LO, 32'h0000_0000);
    chk(v[29:0], e);
    bus(1'b0, acf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(v, 32'h0003_f011);
    bus(1'b0, acf_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    chk(v[11:0], 12'h03f);
    bus(1'b1, acf_pkg::ADDR_IRQ_MASK, 32'h0000_0fff);
    @(negedge mclk_i);
    chk(irq, 1'b1);
    bus(1'b1, acf_pkg::ADDR_IRQ_STAT, 32'h0000_003f);
    bus(1'b0, acf_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    chk(v[11:0], 12'h000);
    chk(irq, 1'b0);
    bus(1'b0, 4'h2, 32'h0000_0000);
    chk(v, 32'h0000_0000);
    $display("fill test done");
    idx = '{0, 0, 0, 0, 0, 0};
    pop <= 6'h3f;
    repeat (24)
    begin
      @(negedge mclk_i);
      for (int c = 0; c < 6; c++)
        if (m_valid[c])
        begin
          chk(m_data[c*8+:8], 8'(idx[c]));
          idx[c]++;
        end
    end
    @(posedge mclk_i);
    pop <= 6'h00;
    @(negedge mclk_i);
    for (int c = 0; c < 6; c++)
    begin
      chk(count[c*5+:5], bot(c));
      chk(idx[c], top(c) - bot(c));
    end
    bus(1'b0, acf_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    chk(v[11:0], 12'h440);
    chk(irq, 1'b1);
    $display("drain test done");
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    push <= 6'h30;
    repeat (3) @(posedge mclk_i);
    push <= 6'h00;
    @(negedge mclk_i);
    chk(m_valid[5:4], 2'b01);
    chk(irq, 1'b0);
    $display("packet test done");
    close_out();
  end
endmodule : tb_top
